// File: rtl/spm_defs.svh
// Constants of the switch ingress policing and monitoring block
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
`define SPM_CLK_NS 25
`define SPM_CIR_STEP_NS 20
`define SPM_CIR_MIN 4
`define SPM_THROT_NS 1720000
`define SPM_THROT_SHIFT 6
`define SPM_BKT_INIT 16'h0600
`define SPM_BUF_CAP_RST 9'h100
`define SPM_PORTS 3
`define SPM_STREAMS 24
`define SPM_A_RATE_CFG 8'h00
`define SPM_A_RATE_CMD 8'h04
`define SPM_A_RATE_WDATA 8'h08
`define SPM_A_THROT 8'h0c
`define SPM_A_BUFCAP 8'h10
`define SPM_A_GCFG 8'h14
`define SPM_A_MIRROR 8'h18
`define SPM_A_STATUS 8'h1c
`define SPM_RC_EN 0
`define SPM_RC_MODE 2:1
`define SPM_CMD_IDX 4:0
`define SPM_CMD_SEL 9:8
`define SPM_CMD_GO 15
`define SPM_SEL_CIR 2'h0
`define SPM_SEL_CBS 2'h1
`define SPM_SEL_EBS 2'h2
`define SPM_TH_LVL 23:0
`define SPM_TH_EN 24
`define SPM_BUFCAP 8:0
`define SPM_GCFG 6:0
`define SPM_G_IGMP 0
`define SPM_G_MLD 1
`define SPM_G_OTHER 2
`define SPM_G_ANYHBH 3
`define SPM_G_ECHO 4
`define SPM_G_MONP 6:5
`define SPM_MIR 7:0
`define SPM_M_RX 0
`define SPM_M_TX 1
`define SPM_M_RXF 2
`define SPM_M_MASK 5:3
`define SPM_M_SNIF 7:6
`define SPM_RESP_OKAY 2'h0
`define SPM_RESP_SLVERR 2'h2
`define SPM_HDR_LIMIT 7'd64
`define SPM_ET_POS 7'd12
`define SPM_TAG_LEN 7'd4
`define SPM_SNAP_LEN 7'd8
`define SPM_ET_VLAN 16'h8100
`define SPM_ET_LENMAX 16'h0600
`define SPM_ET_IP4 16'h0800
`define SPM_ET_IP6 16'h86dd
`define SPM_V4_PROTO 7'd9
`define SPM_V4_DST 7'd16
`define SPM_V4_MC 4'he
`define SPM_V6_NH 7'd6
`define SPM_V6_DST 7'd24
`define SPM_V6_MC 8'hff
`define SPM_V6_HBHNH 7'd40
`define SPM_PROTO_IGMP 8'h02
`define SPM_NH_HBH 8'h00
`define SPM_NH_ICMP6 8'h3a
`define SPM_NH_RT 8'h2b
`define SPM_NH_FRAG 8'h2c
`define SPM_NH_ESP 8'h32
`define SPM_NH_AH 8'h33
`define SPM_NH_DST 8'h3c
`endif

// File: rtl/spm_pkg.sv
// Types shared by the ingress policing block
`include "spm_defs.svh"
package spm_pkg;
  typedef enum logic [1:0] {COL_GREEN = 2'h0, COL_YELLOW = 2'h1, COL_RED = 2'h2} spm_colour_t;
  typedef enum logic [1:0] {MODE_PORT = 2'h0, MODE_PRI = 2'h1, MODE_BOTH = 2'h2} spm_mode_t;
  typedef enum logic [3:0] {PS_ETH = 4'h1, PS_IP4 = 4'h2, PS_IP6 = 4'h4, PS_OTHER = 4'h8} spm_pstate_t;
  // Forwarding facts about one packet, given with its last byte
  typedef struct packed {
    logic [1:0] srcPort;
    logic [2:0] pri;
    logic [11:0] len;
    logic [4:0] blocks;
    logic isBcast;
    logic isFlood;
    logic [2:0] fwdMask;
    logic filtered;
    logic portDisabled;
    logic stpBlocked;
    logic stpOverride;
    logic admitViol;
    logic vidFff;
    logic memberViol;
  } spm_desc_t;
  // Final decision for one packet
  typedef struct packed {
    logic valid;
    logic [2:0] dstMask;
    spm_colour_t colour;
    logic randomDiscard;
    logic monitored;
    logic dropped;
  } spm_verdict_t;
  typedef struct packed {
    logic igmp;
    logic mld;
  } spm_hdr_t;
  // Header parser state
  typedef struct packed {
    spm_pstate_t st;
    logic [6:0] idx;
    logic [6:0] etPos;
    logic [6:0] l3;
    logic [7:0] typeHi;
    logic p2;
    logic mc;
    logic nhHit;
    logic hbh;
    logic hbhHit;
    spm_hdr_t res;
  } spm_pst_t;
  // Policer state: registers, buckets, bus and verdict
  typedef struct packed {
    logic rateEn;
    spm_mode_t mode;
    logic [15:0] cmd;
    logic [15:0] wdata;
    logic [15:0] cbs;
    logic [15:0] ebs;
    logic [`SPM_STREAMS-1:0][15:0] cir;
    logic [`SPM_STREAMS-1:0][15:0] cBkt;
    logic [`SPM_STREAMS-1:0][15:0] eBkt;
    logic [`SPM_STREAMS-1:0][20:0] acc;
    logic thEn;
    logic [`SPM_PORTS-1:0][7:0] thLvl;
    logic [`SPM_PORTS-1:0][15:0] thUsed;
    logic [16:0] thTmr;
    logic [8:0] bufCap;
    logic [8:0] bufOcc;
    logic [6:0] gcfg;
    logic [7:0] mir;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic pendValid;
    spm_desc_t pend;
    spm_verdict_t verdict;
    spm_colour_t lastCol;
  } spm_state_t;
endpackage : spm_pkg

// File: rtl/spm_hdr_parser.sv
// Header parser spotting IGMP and MLD multicast in the first bytes
`timescale 1ns/100ps
`include "spm_defs.svh"
module spm_hdr_parser
  import spm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstN,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic byteLast,
  input wire logic otherNh,
  input wire logic anyHbh,
  output spm_hdr_t hdr
);
  spm_pst_t q, d, n;
  logic [6:0] rel; // Offset inside the network header
  logic [15:0] etype; // Type field being completed

  // Start-of-packet state
  function automatic spm_pst_t spm_start();
    spm_pst_t s;
    s = '0;
    s.st = PS_ETH;
    s.etPos = `SPM_ET_POS;
    return s;
  endfunction : spm_start

  // Next headers that qualify as MLD candidates
  function automatic logic spm_nh_hit(input logic [7:0] v, input logic other);
    spm_nh_hit = (v == `SPM_NH_ICMP6) ||
      (other && (v == `SPM_NH_RT || v == `SPM_NH_FRAG || v == `SPM_NH_ESP ||
      v == `SPM_NH_AH || v == `SPM_NH_DST));
  endfunction : spm_nh_hit

  // Walk the header one byte at a time
  always_comb begin
    n = q;
    rel = q.idx - q.l3;
    etype = {q.typeHi, byteData};
    if (byteValid && q.idx < `SPM_HDR_LIMIT) begin
      n.idx = q.idx + 7'h1;
      case (q.st)
        PS_ETH: begin
          if (q.idx == q.etPos) begin
            n.typeHi = byteData;
          end else if (q.idx == q.etPos + 7'h1) begin
            if (etype == `SPM_ET_VLAN) begin // Tag: type moves on
              n.etPos = q.etPos + `SPM_TAG_LEN;
            end else if (etype < `SPM_ET_LENMAX) begin // Length field: skip LLC/SNAP
              n.etPos = q.etPos + `SPM_SNAP_LEN;
            end else if (etype == `SPM_ET_IP4) begin
              n.st = PS_IP4;
              n.l3 = q.idx + 7'h1;
            end else if (etype == `SPM_ET_IP6) begin
              n.st = PS_IP6;
              n.l3 = q.idx + 7'h1;
            end else begin
              n.st = PS_OTHER;
            end
          end
        end
        PS_IP4: begin
          if (rel == `SPM_V4_PROTO) begin
            n.p2 = (byteData == `SPM_PROTO_IGMP);
          end else if (rel == `SPM_V4_DST) begin
            n.mc = (byteData[7:4] == `SPM_V4_MC);
          end
        end
        PS_IP6: begin
          if (rel == `SPM_V6_NH) begin
            n.nhHit = spm_nh_hit(byteData, otherNh);
            n.hbh = (byteData == `SPM_NH_HBH);
          end else if (rel == `SPM_V6_DST) begin
            n.mc = (byteData == `SPM_V6_MC);
          end else if (rel == `SPM_V6_HBHNH) begin
            n.hbhHit = anyHbh || spm_nh_hit(byteData, otherNh);
          end
        end
        default: begin
        end
      endcase
    end
    d = n;
    // Last byte: publish result and rearm for the next packet
    if (byteValid && byteLast) begin
      d = spm_start();
      d.res.igmp = (n.st == PS_IP4) && n.p2 && n.mc;
      d.res.mld = (n.st == PS_IP6) && n.mc && (n.nhHit || (n.hbh && n.hbhHit));
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      q <= spm_start();
    end else begin
      q <= d;
    end
  end

  assign hdr = q.res;
endmodule : spm_hdr_parser

// File: rtl/spm_ingress_policer.sv
// Ingress metering, storm control, monitor trap and port mirroring
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "spm_defs.svh"
module spm_ingress_policer
  import spm_pkg::*;
#(
  parameter int THROT_CYCLES = `SPM_THROT_NS / `SPM_CLK_NS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic byteLast,
  input wire spm_desc_t desc,
  input wire logic bufRelease,
  output spm_verdict_t verdict
);
  logic [1:0] rstSync; // Reset release pipeline
  logic rstN; // Synchronised reset
  spm_state_t q, d; // Whole state and its next value
  spm_hdr_t hdr; // Parser result for the pending packet
  spm_desc_t p; // Pending packet
  logic [4:0] sIdx; // Metering stream
  logic [20:0] perNs; // Time per token in ns
  logic [15:0] len16; // Packet length in tokens
  logic [15:0] thLim; // Broadcast budget of the port
  logic mon, hard, filt, bcDrop, capDrop, drop;
  logic [2:0] dst, out, snif, mirMask, srcOh;
  logic [9:0] occSum; // Occupancy if admitted
  logic [9:0] occNext;
  logic [32:0] rv, wv; // Mapped flag and word
  logic [31:0] wm; // Write data merged by strobes
  spm_colour_t col;

  // Reset values: buckets full at the start-up level
  function automatic spm_state_t spm_reset_val();
    spm_state_t s;
    s = '0;
    s.mode = MODE_PORT;
    s.cbs = `SPM_BKT_INIT;
    s.ebs = `SPM_BKT_INIT;
    s.bufCap = `SPM_BUF_CAP_RST;
    for (int i = 0; i < `SPM_STREAMS; i++) begin
      s.cBkt[i] = `SPM_BKT_INIT;
      s.eBkt[i] = `SPM_BKT_INIT;
    end
    return s;
  endfunction : spm_reset_val

  // Register view at an address; bit 32 marks a mapped word
  function automatic logic [32:0] spm_view(input spm_state_t s, input logic [7:0] a);
    logic [32:0] v;
    v = 33'h0;
    if (a == `SPM_A_RATE_CFG) begin
      v = {1'b1, 29'h0, s.mode, s.rateEn};
    end else if (a == `SPM_A_RATE_CMD) begin
      v = {1'b1, 16'h0, s.cmd};
    end else if (a == `SPM_A_RATE_WDATA) begin
      v = {1'b1, 16'h0, s.wdata};
    end else if (a == `SPM_A_THROT) begin
      v = {1'b1, 7'h0, s.thEn, s.thLvl};
    end else if (a == `SPM_A_BUFCAP) begin
      v = {1'b1, 23'h0, s.bufCap};
    end else if (a == `SPM_A_GCFG) begin
      v = {1'b1, 25'h0, s.gcfg};
    end else if (a == `SPM_A_MIRROR) begin
      v = {1'b1, 24'h0, s.mir};
    end else if (a == `SPM_A_STATUS) begin
      v = {1'b1, 19'h0, s.bufOcc, 2'h0, s.lastCol};
    end
    return v;
  endfunction : spm_view

  // Byte-lane merge of a write
  function automatic logic [31:0] spm_merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = w[b*8 +: 8];
      end
    end
    return r;
  endfunction : spm_merge

  // Reset is released through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // Header inspection runs beside the packet bytes
  spm_hdr_parser u_parser (
    .core_clk(core_clk),
    .rstN(rstN),
    .byteValid(byteValid),
    .byteData(byteData),
    .byteLast(byteLast),
    .otherNh(q.gcfg[`SPM_G_OTHER]),
    .anyHbh(q.gcfg[`SPM_G_ANYHBH]),
    .hdr(hdr)
  );

  // Next-state logic
  always_comb begin
    d = q;
    d.verdict.valid = 1'b0;
    p = q.pend;
    perNs = 21'h0;
    sIdx = 5'h0;
    len16 = {4'h0, p.len};
    thLim = 16'h0;
    mon = 1'b0;
    hard = 1'b0;
    filt = 1'b0;
    bcDrop = 1'b0;
    capDrop = 1'b0;
    drop = 1'b0;
    dst = 3'h0;
    out = 3'h0;
    snif = 3'h1 << q.mir[`SPM_M_SNIF];
    mirMask = q.mir[`SPM_M_MASK];
    srcOh = 3'h1 << p.srcPort;
    occSum = 10'(q.bufOcc) + 10'(p.blocks);
    occNext = 10'(q.bufOcc);
    col = COL_GREEN;
    rv = 33'h0;
    wv = 33'h0;
    wm = 32'h0;

    // Token credit at each stream's own rate
    for (int i = 0; i < `SPM_STREAMS; i++) begin
      if (q.cir[i] < 16'(`SPM_CIR_MIN)) begin // Low settings all run at the floor
        perNs = 21'(`SPM_CIR_MIN * `SPM_CIR_STEP_NS);
      end else begin
        perNs = 21'(q.cir[i]) * 21'(`SPM_CIR_STEP_NS);
      end
      if (q.rateEn) begin
        if (q.acc[i] + 21'(`SPM_CLK_NS) >= perNs) begin
          // Period above one clock, so at most one token per cycle
          d.acc[i] = q.acc[i] + 21'(`SPM_CLK_NS) - perNs;
          if (q.cBkt[i] < q.cbs) begin
            d.cBkt[i] = q.cBkt[i] + 16'h1;
          end else if (q.eBkt[i] < q.ebs) begin
            d.eBkt[i] = q.eBkt[i] + 16'h1;
          end
        end else begin
          d.acc[i] = q.acc[i] + 21'(`SPM_CLK_NS);
        end
      end
    end

    // Broadcast interval clears all port budgets
    if (q.thTmr == 17'(THROT_CYCLES - 1)) begin
      d.thTmr = 17'h0;
      d.thUsed = '0;
    end else begin
      d.thTmr = q.thTmr + 17'h1;
    end

    // Stream choice; priority arrives already unmapped by traffic class
    case (q.mode)
      MODE_PRI: sIdx = {2'h0, p.pri};
      MODE_BOTH: sIdx = {p.srcPort, p.pri};
      default: sIdx = {3'h0, p.srcPort};
    endcase

    // Decide the pending packet one cycle after its last byte
    if (q.pendValid) begin
      mon = (q.gcfg[`SPM_G_IGMP] && hdr.igmp) || (q.gcfg[`SPM_G_MLD] && hdr.mld);
      hard = p.portDisabled || (p.stpBlocked && !p.stpOverride) || p.admitViol ||
        p.vidFff || p.memberViol;
      filt = mon ? hard : p.filtered;
      dst = mon ? (3'h1 << q.gcfg[`SPM_G_MONP]) : p.fwdMask;
      thLim = 16'(q.thLvl[p.srcPort]) << `SPM_THROT_SHIFT;
      bcDrop = q.thEn && p.isBcast && (q.thUsed[p.srcPort] + len16 > thLim);
      capDrop = p.isFlood && (occSum > 10'(q.bufCap));
      if (q.rateEn) begin
        if (d.cBkt[sIdx] >= len16) begin
          col = COL_GREEN;
        end else if (d.eBkt[sIdx] >= len16) begin
          col = COL_YELLOW;
        end else begin
          col = COL_RED;
        end
      end
      drop = filt || bcDrop || capDrop || (col == COL_RED);
      // Only admitted packets take tokens, budget and buffers
      if (!drop) begin
        if (q.rateEn && col == COL_GREEN) begin
          d.cBkt[sIdx] = d.cBkt[sIdx] - len16;
        end else if (q.rateEn) begin
          d.eBkt[sIdx] = d.eBkt[sIdx] - len16;
        end
        if (p.isBcast) begin
          d.thUsed[p.srcPort] = d.thUsed[p.srcPort] + len16;
        end
        if (p.isFlood) begin
          occNext = occSum;
        end
      end
      out = drop ? 3'h0 : dst;
      if (q.mir[`SPM_M_TX] && (out & mirMask) != 3'h0) begin
        out = out | snif;
      end
      if (q.mir[`SPM_M_RX] && (mirMask & srcOh) != 3'h0 && (!drop || q.mir[`SPM_M_RXF])) begin
        out = out | snif;
      end
      if (!(mon && q.gcfg[`SPM_G_ECHO])) begin
        out = out & ~srcOh;
      end
      d.verdict.valid = 1'b1;
      d.verdict.dstMask = out;
      d.verdict.colour = col;
      d.verdict.randomDiscard = !drop && (col == COL_YELLOW);
      d.verdict.monitored = mon;
      d.verdict.dropped = drop;
      d.lastCol = col;
    end

    // Flood buffers returned one block at a time
    if (bufRelease && occNext != 10'h0) begin
      occNext = occNext - 10'h1;
    end
    d.bufOcc = occNext[8:0];

    // Capture the packet facts with its last byte
    d.pendValid = byteValid && byteLast;
    if (byteValid && byteLast) begin
      d.pend = desc;
    end

    // Write address and data are taken in either order
    if (s_axi_awvalid && !q.awHeld) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wHeld) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    // Both halves present: perform the write
    if (q.awHeld && q.wHeld && !q.bValid) begin
      wv = spm_view(q, q.awAddr);
      wm = spm_merge(wv[31:0], q.wData, q.wStrb);
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bValid = 1'b1;
      d.bResp = wv[32] ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
      if (q.awAddr == `SPM_A_RATE_CFG) begin
        d.rateEn = wm[`SPM_RC_EN];
        d.mode = spm_mode_t'(wm[`SPM_RC_MODE]);
      end else if (q.awAddr == `SPM_A_RATE_CMD) begin
        // Go bit is a strobe and never reads back
        d.cmd = wm[15:0] & ~(16'h1 << `SPM_CMD_GO);
        if (wm[`SPM_CMD_GO]) begin
          if (wm[`SPM_CMD_SEL] == `SPM_SEL_CBS) begin
            d.cbs = q.wdata;
          end else if (wm[`SPM_CMD_SEL] == `SPM_SEL_EBS) begin
            d.ebs = q.wdata;
          end else if (wm[`SPM_CMD_SEL] == `SPM_SEL_CIR && wm[`SPM_CMD_IDX] < 5'(`SPM_STREAMS)) begin
            d.cir[wm[`SPM_CMD_IDX]] = q.wdata;
          end
        end
      end else if (q.awAddr == `SPM_A_RATE_WDATA) begin
        d.wdata = wm[15:0];
      end else if (q.awAddr == `SPM_A_THROT) begin
        d.thLvl = wm[`SPM_TH_LVL];
        d.thEn = wm[`SPM_TH_EN];
      end else if (q.awAddr == `SPM_A_BUFCAP) begin
        d.bufCap = wm[`SPM_BUFCAP];
      end else if (q.awAddr == `SPM_A_GCFG) begin
        d.gcfg = wm[`SPM_GCFG];
      end else if (q.awAddr == `SPM_A_MIRROR) begin
        d.mir = wm[`SPM_MIR];
      end
    end

    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && !q.rValid) begin
      rv = spm_view(q, s_axi_araddr);
      d.rValid = 1'b1;
      d.rData = rv[31:0];
      d.rResp = rv[32] ? `SPM_RESP_OKAY : `SPM_RESP_SLVERR;
    end else if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      q <= spm_reset_val();
    end else begin
      q <= d;
    end
  end

  // Ready terms come straight from the holding flags, arready from rValid
  assign s_axi_awready = !q.awHeld;
  assign s_axi_wready = !q.wHeld;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = !q.rValid;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = q.rData;
  assign s_axi_rresp = q.rResp;
  assign verdict = q.verdict;
endmodule : spm_ingress_policer

// File: sim/spm_ingress_policer_props.sv
// Port-level assertions for the ingress policer
`timescale 1ns/100ps
module spm_ingress_policer_props
  import spm_pkg::*;
#(
  parameter int THROT_CYCLES = 68800
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic byteValid,
  input wire logic byteLast,
  input wire spm_desc_t desc,
  input wire spm_verdict_t verdict
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Every last byte earns one verdict after parse and decide
  a_verdict_late: assert property (byteValid && byteLast |-> ##2 verdict.valid)
    else $error("no verdict");
  a_verdict_cause: assert property (verdict.valid |-> $past(byteLast, 2))
    else $error("stray verdict");
  a_verdict_pulse: assert property (verdict.valid |=> !verdict.valid)
    else $error("long verdict");
  a_red_drop: assert property (verdict.valid && verdict.colour == COL_RED |-> verdict.dropped)
    else $error("red kept");
  a_yellow_random: assert property (verdict.valid && verdict.colour == COL_YELLOW && !verdict.dropped
    |-> verdict.randomDiscard)
    else $error("yellow not marked");
  // Source index taken from the packet that caused the verdict
  a_no_echo: assert property (verdict.valid && !verdict.monitored
    |-> !verdict.dstMask[$past(desc.srcPort, 2)])
    else $error("echo to source");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("late read");
  c_yellow: cover property (verdict.valid && verdict.colour == COL_YELLOW);
  c_monitor: cover property (verdict.valid && verdict.monitored);
  c_mirror: cover property (verdict.valid && verdict.dstMask == 3'b011);
endmodule : spm_ingress_policer_props
bind spm_ingress_policer spm_ingress_policer_props #(.THROT_CYCLES(THROT_CYCLES)) i_spm_ingress_policer_props (.*);

// File: sim/spm_mac_model.sv
// Packet source standing in for the port receive MACs
`timescale 1ns/100ps
module spm_mac_model
  import spm_pkg::*;
(
  input wire logic core_clk,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic byteLast,
  output spm_desc_t desc
);
  logic [7:0] b [64];
  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
    byteLast = 1'b0;
    desc = '0;
  end
  // Header of 64 bytes; f picks Ethernet II, VLAN tag or LLC/SNAP
  task send(input int f, k, input logic [7:0] nh, hnh, input spm_desc_t d);
    int o;
    int i;
    o = 12 + (f == 1 ? 4 : f == 2 ? 8 : 0);
    for (i = 0; i < 64; i++) b[i] = 8'h00;
    if (f == 1) {b[12], b[13]} = 16'h8100;
    if (f == 2) begin
      b[13] = 8'h40;
      b[14] = 8'haa;
      b[15] = 8'haa;
      b[16] = 8'h03;
    end
    {b[o], b[o+1]} = (k == 2) ? 16'h86dd : 16'h0800;
    if (k == 1) begin
      b[o+11] = 8'h02;
      b[o+18] = 8'he0;
    end
    if (k == 2) begin
      b[o+8] = nh;
      b[o+26] = 8'hff;
      b[o+42] = hnh;
    end
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      byteValid <= 1'b1;
      byteData <= b[i];
      byteLast <= (i == 63);
      desc <= d;
    end
    @(posedge core_clk);
    byteValid <= 1'b0;
    byteLast <= 1'b0;
    byteData <= ~b[63]; // Idle line must not look like a held byte
  endtask : send
endmodule : spm_mac_model

// File: sim/spm_ingress_policer_tb_top.sv
// Register and packet tests for the ingress policer
`timescale 1ns/100ps
module spm_ingress_policer_tb_top
  import spm_pkg::*;
;
  localparam int TH = 20000; // Short storm interval keeps the run brief
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, bufRelease = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, byteValid, byteLast;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] byteData;
  logic [7:0] nhs [5] = '{8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c};
  spm_desc_t desc;
  spm_verdict_t verdict;
  int err_total = 0;
  int n_checks = 0;
  int i;
  spm_ingress_policer #(.THROT_CYCLES(TH)) i_spm_ingress_policer (.*);
  spm_mac_model i_spm_mac_model (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task report_and_stop;
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [33:0] s, e);
    n_checks++;
    if (s !== e) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      err_total++;
    end
  endtask : chk
  task tmo(input int n);
    if (n >= 40) begin
      err_total++;
      report_and_stop;
    end
  endtask : tmo
  // Write: both channels offered at once, bready held up until the response is seen
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
    chk(34'(s_axi_bresp), 34'h0);
  endtask : wr
  // Read: e holds response code above the data word
  task rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n);
    chk({s_axi_rresp, s_axi_rdata}, e);
  endtask : rd
  // Packet; x = bcast, flood, filtered, vid FFF; e = colour, rd, mon, drop, dst
  task pk(input int f, k, input logic [7:0] nh, hnh, input logic [1:0] s, input logic [2:0] fw,
          input logic [11:0] ln, input logic [3:0] x, input logic [7:0] e);
    spm_desc_t d;
    int n;
    d = '0;
    d.srcPort = s;
    d.len = ln;
    d.blocks = 5'd1;
    d.fwdMask = fw;
    {d.isBcast, d.isFlood, d.filtered, d.vidFff} = x;
    i_spm_mac_model.send(f, k, nh, hnh, d);
    for (n = 0; n < 40 && verdict.valid !== 1'b1; n++) @(posedge core_clk);
    tmo(n);
    chk(34'({verdict.colour, verdict.randomDiscard, verdict.monitored, verdict.dropped, verdict.dstMask}), 34'(e));
  endtask : pk
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(8'h10, 34'h100);
    rd(8'h20, 34'h200000000);
    wr(8'h18, 32'h21);
    rd(8'h18, 34'h21);
    wr(8'h08, 32'hffff);
    wr(8'h04, 32'h8001);
    wr(8'h00, 32'h1);
    pk(0, 0, 0, 0, 1, 3'b100, 1536, 0, 8'h04);
    pk(0, 0, 0, 0, 1, 3'b100, 1000, 0, 8'h64);
    pk(0, 0, 0, 0, 1, 3'b100, 1000, 0, 8'h88);
    rd(8'h1c, 34'h2);
    wr(8'h00, 32'h3);
    pk(0, 0, 0, 0, 1, 3'b100, 1000, 0, 8'h04);
    wr(8'h00, 32'h5);
    pk(0, 0, 0, 0, 1, 3'b100, 1000, 0, 8'h04);
    // Committed cap of 100 loaded; a drained stream then refills no further than that
    wr(8'h08, 32'h64);
    wr(8'h04, 32'h8100);
    wr(8'h00, 32'h1);
    pk(0, 0, 0, 0, 2, 3'b001, 1536, 0, 8'h01);
    repeat (400) @(posedge core_clk);
    pk(0, 0, 0, 0, 2, 3'b001, 101, 0, 8'h61);
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h3);
    for (i = 0; i < 3; i++) pk(i, 1, 0, 0, 1, 3'b100, 64, 0, 8'h11);
    pk(0, 2, 8'h3a, 0, 1, 3'b100, 64, 0, 8'h11);
    pk(0, 2, 8'h00, 8'h3a, 1, 3'b100, 64, 0, 8'h11);
    pk(0, 2, 8'h2b, 0, 1, 3'b100, 64, 0, 8'h04);
    wr(8'h14, 32'h7);
    for (i = 0; i < 5; i++) pk(0, 2, nhs[i], 0, 1, 3'b100, 64, 0, 8'h11);
    pk(0, 2, 8'h00, 8'h11, 1, 3'b100, 64, 0, 8'h04);
    wr(8'h14, 32'hf);
    pk(0, 2, 8'h00, 8'h11, 1, 3'b100, 64, 0, 8'h11);
    pk(0, 1, 0, 0, 0, 3'b010, 64, 0, 8'h10);
    wr(8'h14, 32'h1f);
    pk(0, 1, 0, 0, 0, 3'b010, 64, 0, 8'h11);
    pk(0, 1, 0, 0, 1, 3'b100, 64, 4'b0010, 8'h11);
    pk(0, 1, 0, 0, 1, 3'b100, 64, 4'b0001, 8'h18);
    wr(8'h14, 32'h0);
    pk(0, 0, 0, 0, 2, 3'b010, 64, 0, 8'h03);
    wr(8'h18, 32'h22);
    pk(0, 0, 0, 0, 1, 3'b100, 64, 0, 8'h05);
    wr(8'h18, 32'h21);
    pk(0, 0, 0, 0, 2, 3'b010, 64, 4'b0010, 8'h08);
    wr(8'h18, 32'h25);
    pk(0, 0, 0, 0, 2, 3'b010, 64, 4'b0010, 8'h09);
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h1);
    pk(0, 0, 0, 0, 1, 3'b110, 64, 4'b0100, 8'h04);
    pk(0, 0, 0, 0, 1, 3'b110, 64, 4'b0100, 8'h08);
    @(posedge core_clk);
    bufRelease <= 1'b1;
    @(posedge core_clk);
    bufRelease <= 1'b0;
    pk(0, 0, 0, 0, 1, 3'b110, 64, 4'b0100, 8'h04);
    wr(8'h10, 32'h100);
    wr(8'h0c, 32'h1000200);
    pk(0, 0, 0, 0, 1, 3'b101, 100, 4'b1100, 8'h05);
    pk(0, 0, 0, 0, 1, 3'b101, 100, 4'b1100, 8'h08);
    repeat (TH) @(posedge core_clk);
    pk(0, 0, 0, 0, 1, 3'b101, 100, 4'b1100, 8'h05);
    report_and_stop;
  end
endmodule : spm_ingress_policer_tb_top
